/* File: rtl/ewps_pkg.sv */
// constants for the write-protect and status block of a serial eeprom
// assumes a host spi controller in mode 0, chip select active low
// Notes on behaviour
// - no internal write unless latch is set
// - latch clears on reset, commands, guard low
// - status read answered even while busy
// - status: busy b0, latch b1, protect b3:2
// - busy reads one during internal write only
// - latch set/clear works despite status protection
// - protect bits kept, changed only by status-write
// - protect code: none, quarter, half, all
// - protected ranges per density, upper portions
// - guard low or latch clear rejects writes
// - write starts only on correctly timed deselect
// - access other than status-read during internal write is ignored
// - power-on: standby, latch clear, output off
// - inactive until first chip-select falling edge
// - latch-set 0000x110, latch-clear 0000x100, msb first
// - status-read 0000x101, status-write 0000x001
// - latch set only on deselect after eight bits
// - guard low never aborts running write
package ewps_pkg;
	localparam logic [2:0] EWPS_OP_LATCH_SET = 3'h6;
	localparam logic [2:0] EWPS_OP_LATCH_CLR = 3'h4;
	localparam logic [2:0] EWPS_OP_STAT_RD = 3'h5;
	localparam logic [2:0] EWPS_OP_STAT_WR = 3'h1;
	localparam logic [2:0] EWPS_OP_ARR_WR = 3'h2;
	localparam logic [2:0] EWPS_OP_ARR_RD = 3'h3;
	localparam int EWPS_BIT_BUSY = 0;
	localparam int EWPS_BIT_LATCH = 1;
	localparam int EWPS_BIT_PROT_LO = 2;
	localparam int EWPS_BIT_PROT_HI = 3;
	localparam logic [1:0] EWPS_PROT_RESET = 2'h0;
	localparam logic [1:0] EWPS_PROT_NONE = 2'h0;
	localparam logic [1:0] EWPS_PROT_QUARTER = 2'h1;
	localparam logic [1:0] EWPS_PROT_HALF = 2'h2;
	localparam logic [8:0] EWPS_Q_BASE_128 = 9'h060;
	localparam logic [8:0] EWPS_H_BASE_128 = 9'h040;
	localparam logic [8:0] EWPS_Q_BASE_256 = 9'h0C0;
	localparam logic [8:0] EWPS_H_BASE_256 = 9'h080;
	localparam logic [8:0] EWPS_Q_BASE_512 = 9'h180;
	localparam logic [8:0] EWPS_H_BASE_512 = 9'h100;
	localparam logic [1:0] EWPS_DENS_128 = 2'h0;
	localparam logic [1:0] EWPS_DENS_256 = 2'h1;
	localparam logic [1:0] EWPS_DENS_512 = 2'h2;
	localparam int EWPS_CLK_MHZ = 25;
	localparam int EWPS_WRITE_TIME_US = 6000;
	localparam int EWPS_WRITE_CYC = EWPS_WRITE_TIME_US * EWPS_CLK_MHZ;
	typedef enum logic [4:0] {
		EWPS_IDLE = 5'h01,
		EWPS_CMD = 5'h02,
		EWPS_ADDR = 5'h04,
		EWPS_DATA = 5'h08,
		EWPS_DONE = 5'h10
	} ewps_state_type;
endpackage

/* File: rtl/ewps_protect_map.sv */
// address protection decoder for the array write path
// assumes address and density from the same clock domain
module ewps_protect_map
	import ewps_pkg::*;
(
	input wire logic [1:0] density,
	input wire logic [1:0] protect_level,
	input wire logic [8:0] addr,
	output logic addr_protected
);
	logic [8:0] q_base;
	logic [8:0] h_base;
	assign q_base = (density == EWPS_DENS_512) ? EWPS_Q_BASE_512 :
		(density == EWPS_DENS_256) ? EWPS_Q_BASE_256 : EWPS_Q_BASE_128;
	assign h_base = (density == EWPS_DENS_512) ? EWPS_H_BASE_512 :
		(density == EWPS_DENS_256) ? EWPS_H_BASE_256 : EWPS_H_BASE_128;
	always_comb
	begin
		case (protect_level)
			EWPS_PROT_NONE: addr_protected = 1'b0;
			EWPS_PROT_QUARTER: addr_protected = (addr >= q_base);
			EWPS_PROT_HALF: addr_protected = (addr >= h_base);
			default: addr_protected = 1'b1;
		endcase
	end
endmodule // ewps_protect_map

/* File: rtl/ewps_core.sv */
// spi front end, write enable latch, status register and write timer
// assumes spi mode 0 from the host; pins are asynchronous to clk
module ewps_core
	import ewps_pkg::*;
#(
	parameter int WRITE_CYC = EWPS_WRITE_CYC
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [1:0] density,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic guard_n,
	output logic so,
	output logic so_oe,
	output logic write_busy_flag,
	output logic write_latch_flag,
	output logic [1:0] protect_level,
	output logic array_write_start,
	output logic [8:0] array_write_addr
);
	////////////////////////////////////////////////////////////////////
	// synchronisers
	logic [1:0] sck_s, cs_s, si_s, wg_s;
	logic sck_d;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sck_s <= 2'h0;
			cs_s <= 2'h3;
			si_s <= 2'h0;
			wg_s <= 2'h0;
			sck_d <= 1'b0;
		end
		else
		begin
			sck_s <= {sck_s[0], sck};
			cs_s <= {cs_s[0], cs_n};
			si_s <= {si_s[0], si};
			wg_s <= {wg_s[0], guard_n};
			sck_d <= sck_s[1];
		end
	end
	logic cs_q_reg;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cs_q_reg <= 1'b1;
		else
			cs_q_reg <= cs_s[1];
	end
	wire sel = ~cs_s[1];
	wire cs_fall = cs_q_reg & ~cs_s[1];
	wire cs_rise = ~cs_q_reg & cs_s[1];
	wire sck_rise = sel & sck_s[1] & ~sck_d;
	wire sck_fall = sel & ~sck_s[1] & sck_d;
	wire guard_hi = wg_s[1];
	////////////////////////////////////////////////////////////////////
	// frame shifter
	ewps_state_type state_reg, state_next;
	logic armed_reg;
	logic [7:0] shift_reg;
	logic [2:0] bitcnt_reg;
	logic [2:0] op_reg;
	logic [8:0] addr_reg;
	logic [7:0] data_reg;
	logic byte_end_reg;
	logic [7:0] so_sh_reg;
	logic latch_reg;
	// nonvolatile: starts from the shipped setting, untouched by rstn
	logic [1:0] prot_reg = EWPS_PROT_RESET;
	logic busy_reg;
	logic [22:0] wcnt_reg;
	logic data_seen_reg;
	wire [7:0] shift_in = {shift_reg[6:0], si_s[1]};
	wire byte_done = sck_rise & (bitcnt_reg == 3'h7);
	wire [7:0] status_byte = {4'h0, prot_reg, latch_reg, busy_reg};
	// address bits above the array size are don't care
	wire [8:0] addr_eff = (density == EWPS_DENS_512) ? addr_reg :
		(density == EWPS_DENS_256) ? {1'h0, addr_reg[7:0]} :
		{2'h0, addr_reg[6:0]};
	logic addr_prot;
	ewps_protect_map u_map (
		.density(density),
		.protect_level(prot_reg),
		.addr(addr_eff),
		.addr_protected(addr_prot)
	);
	wire write_ok = guard_hi & latch_reg;
	// deselect exactly on a byte boundary after a full byte
	wire clean_end = cs_rise & byte_end_reg & (bitcnt_reg == 3'h0);
	wire op_valid = (shift_in[7:4] == 4'h0);
	wire [2:0] op_in = shift_in[2:0];
	// state transitions; one frame is command, optional address, data
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			EWPS_IDLE: if (sel && armed_reg) state_next = EWPS_CMD;
			EWPS_CMD:
				if (byte_done)
				begin
					if (!op_valid)
						state_next = EWPS_DONE;
					else if (op_in == EWPS_OP_ARR_WR || op_in == EWPS_OP_ARR_RD)
						state_next = EWPS_ADDR;
					else
						state_next = EWPS_DATA;
				end
			EWPS_ADDR: if (byte_done) state_next = EWPS_DATA;
			EWPS_DATA: state_next = state_reg;
			EWPS_DONE: state_next = state_reg;
			default: state_next = EWPS_IDLE;
		endcase
		if (!sel)
			state_next = EWPS_IDLE;
	end
	// stay inactive until a first chip-select fall
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			armed_reg <= 1'b0;
		else if (cs_fall)
			armed_reg <= 1'b1;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state_reg <= EWPS_IDLE;
		else
			state_reg <= state_next;
	end
	// bit counter and shifter, msb first on sck rising
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			shift_reg <= 8'h00;
			bitcnt_reg <= 3'h0;
			byte_end_reg <= 1'b0;
		end
		else if (state_reg == EWPS_IDLE)
		begin
			bitcnt_reg <= 3'h0;
			byte_end_reg <= 1'b0;
		end
		else if (sck_rise)
		begin
			shift_reg <= shift_in;
			bitcnt_reg <= bitcnt_reg + 3'h1;
			byte_end_reg <= byte_done;
		end
	end
	// capture opcode, address and last data byte
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			op_reg <= 3'h0;
			addr_reg <= 9'h000;
			data_reg <= 8'h00;
		end
		else if (byte_done)
		begin
			if (state_reg == EWPS_CMD)
			begin
				op_reg <= op_valid ? op_in : 3'h0;
				addr_reg <= {shift_in[3], 8'h00};
			end
			else if (state_reg == EWPS_ADDR)
				addr_reg <= {addr_reg[8], shift_in};
			else if (state_reg == EWPS_DATA)
				data_reg <= shift_in;
		end
	end
	// marks a whole byte after the command; writes need one, and it
	// voids a latch set or clear sent without its own deselect
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			data_seen_reg <= 1'b0;
		else if (state_reg == EWPS_IDLE)
			data_seen_reg <= 1'b0;
		else if (byte_done && state_reg == EWPS_DATA)
			data_seen_reg <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////
	// commit on clean deselect
	wire in_data = (state_reg == EWPS_DATA);
	wire got_data = in_data & data_seen_reg
		& (op_reg == EWPS_OP_STAT_WR | op_reg == EWPS_OP_ARR_WR);
	// nothing is committed while a write runs
	wire commit = clean_end & ~busy_reg;
	// latch set only on deselect after the command byte alone
	wire cmd_alone = in_data & ~data_seen_reg;
	wire do_set = commit & cmd_alone & (op_reg == EWPS_OP_LATCH_SET);
	wire do_clr = commit & cmd_alone & (op_reg == EWPS_OP_LATCH_CLR);
	// writes need latch and guard high
	wire do_swr = commit & got_data & (op_reg == EWPS_OP_STAT_WR) & write_ok;
	wire do_awr = commit & got_data & (op_reg == EWPS_OP_ARR_WR) & write_ok
		& ~addr_prot;
	// latch clearing events; guard low wins
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			latch_reg <= 1'b0;
		else if (!guard_hi || do_clr || do_swr || do_awr)
			latch_reg <= 1'b0;
		else if (do_set)
			latch_reg <= 1'b1;
	end
	// protect bits change only by status-write
	// no reset: as nonvolatile bits they must survive a power cycle
	always_ff @(posedge clk)
	begin
		if (do_swr)
			prot_reg <= data_reg[EWPS_BIT_PROT_HI:EWPS_BIT_PROT_LO];
	end
	// busy timer, guard pin has no say once started
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy_reg <= 1'b0;
			wcnt_reg <= 23'h000000;
		end
		else if (do_swr || do_awr)
		begin
			busy_reg <= 1'b1;
			wcnt_reg <= 23'(WRITE_CYC - 1);
		end
		else if (busy_reg)
		begin
			if (wcnt_reg == 23'h000000)
				busy_reg <= 1'b0;
			else
				wcnt_reg <= wcnt_reg - 23'h000001;
		end
	end
	// status read served any time; shifted out on sck falling
	wire rd_load = byte_done & (state_reg == EWPS_CMD) & op_valid
		& (op_in == EWPS_OP_STAT_RD);
	wire rd_active = in_data & (op_reg == EWPS_OP_STAT_RD);
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			so_sh_reg <= 8'h00;
		else if (rd_load)
			so_sh_reg <= status_byte;
		else if (rd_active && sck_fall)
			so_sh_reg <= (bitcnt_reg == 3'h0) ? status_byte
				: {so_sh_reg[6:0], 1'b0};
	end
	// output released outside a status read
	logic so_oe_reg;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			so_oe_reg <= 1'b0;
		else
			so_oe_reg <= rd_active & sel;
	end
	assign so = so_sh_reg[7];
	assign so_oe = so_oe_reg;
	assign write_busy_flag = status_byte[EWPS_BIT_BUSY];
	assign write_latch_flag = status_byte[EWPS_BIT_LATCH];
	assign protect_level = prot_reg;
	// array write handoff pulse
	logic awr_reg;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			awr_reg <= 1'b0;
		else
			awr_reg <= do_awr;
	end
	assign array_write_start = awr_reg;
	assign array_write_addr = addr_reg;
endmodule // ewps_core

/* File: tb/ewps_core_monitor.sv */
// port-level assertions for the write-protect core
// assumes one clock domain and an async low reset
module ewps_core_monitor
	import ewps_pkg::*;
#(
	parameter int WRITE_CYC = EWPS_WRITE_CYC
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic guard_n,
	input wire logic so_oe,
	input wire logic write_busy_flag,
	input wire logic write_latch_flag,
	input wire logic [1:0] protect_level,
	input wire logic array_write_start
);
	timeunit 1ns;
	timeprecision 1ns;
	int busy_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// busy run length; a short cycle would leave cells half written
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			busy_cnt <= 0;
		else
			busy_cnt <= write_busy_flag ? busy_cnt + 1 : 0;
	sequence s_wr_begin;
		$rose(write_busy_flag);
	endsequence
	property p_wr_latch;
		s_wr_begin |-> $past(write_latch_flag) ||
			$past(write_latch_flag, 2) || $past(write_latch_flag, 3);
	endproperty
	property p_wr_clear;
		s_wr_begin |-> ##[0:4] !write_latch_flag;
	endproperty
	property p_guard;
		!guard_n [*5] |-> !write_latch_flag;
	endproperty
	property p_busy_len;
		$fell(write_busy_flag) |->
			busy_cnt >= WRITE_CYC && busy_cnt <= WRITE_CYC + 1;
	endproperty
	property p_prot;
		!$stable(protect_level) |-> ##[0:3] write_busy_flag;
	endproperty
	property p_oe;
		cs_n [*5] |-> !so_oe;
	endproperty
	property p_start_cs;
		array_write_start |-> $past(cs_n);
	endproperty
	property p_start_all;
		array_write_start |-> protect_level != 2'h3;
	endproperty
	a_wr_latch: assert property (p_wr_latch)
		else $error("write began without latch");
	a_wr_clear: assert property (p_wr_clear)
		else $error("latch kept after write");
	a_guard: assert property (p_guard)
		else $error("latch set with guard low");
	a_busy_len: assert property (p_busy_len)
		else $error("busy length off");
	a_prot: assert property (p_prot)
		else $error("protect changed without write");
	a_oe: assert property (p_oe)
		else $error("output on while deselected");
	a_start_cs: assert property (p_start_cs)
		else $error("write start while selected");
	a_start_all: assert property (p_start_all)
		else $error("write start with all protected");
endmodule // ewps_core_monitor

bind ewps_core ewps_core_monitor #(.WRITE_CYC(WRITE_CYC)) u_mon (
	.clk(clk),
	.rstn(rstn),
	.cs_n(cs_n),
	.guard_n(guard_n),
	.so_oe(so_oe),
	.write_busy_flag(write_busy_flag),
	.write_latch_flag(write_latch_flag),
	.protect_level(protect_level),
	.array_write_start(array_write_start)
);

/* File: tb/ewps_host_model.sv */
// host spi controller model, mode 0, msb first
// assumes the bench clock; sck runs only inside frames
module ewps_host_model
(
	input wire logic clk,
	input wire logic so,
	output logic sck,
	output logic cs_n,
	output logic si
);
	timeunit 1ns;
	timeprecision 1ns;
	int half = 4;
	// idle: deselected, clock low
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b1;
	end
	// n bits from the top of d; rd keeps the last 8 read
	task automatic xfer(input logic [23:0] d, input int n,
		output logic [7:0] rd);
		rd = 8'h00;
		@(negedge clk) cs_n <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			si <= d[23 - i];
			repeat (half) @(negedge clk);
			sck <= 1'b1;
			rd = {rd[6:0], so};
			repeat (half) @(negedge clk);
			sck <= 1'b0;
		end
		repeat (4) @(negedge clk);
		cs_n <= 1'b1;
		si <= ~si;
		repeat (6) @(negedge clk);
	endtask
endmodule // ewps_host_model

/* File: tb/ewps_core_tb.sv */
// self-checking bench for the write-protect core
// assumes the host model drives the spi pins
module ewps_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, guard_n, sck, cs_n, si, so, so_oe, busy, latch, start;
	logic [1:0] density, prot, e_prot;
	logic [8:0] waddr, a, sa;
	logic so_line;
	logic [7:0] rd;
	logic e_latch, e_busy, hit;
	int num_errors, samples_checked, starts, n;
	// a released output shows the inverse of its last bit to the host
	assign so_line = so_oe ? so : ~so;
	ewps_host_model u_host (.clk(clk), .so(so_line), .sck(sck),
		.cs_n(cs_n), .si(si));
	ewps_core #(.WRITE_CYC(400)) u_dut (.clk(clk), .rstn(rstn),
		.density(density), .sck(sck), .cs_n(cs_n), .si(si),
		.guard_n(guard_n), .so(so), .so_oe(so_oe), .write_busy_flag(busy),
		.write_latch_flag(latch), .protect_level(prot),
		.array_write_start(start), .array_write_addr(waddr));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// count accepted array writes
	always @(negedge clk)
		if (start === 1'b1)
			starts++;
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	function automatic logic [7:0] op(input logic [2:0] c);
		return {4'h0, 1'($urandom), c};
	endfunction
	// first protected address; top of array means none
	function automatic logic [9:0] base(input logic [1:0] d, l);
		logic [9:0] top;
		top = 10'h080 << d;
		return l == 0 ? top : l == 1 ? top - top / 4 : l == 2 ? top / 2 : 0;
	endfunction
	task automatic cmd(input logic [23:0] d, input int nb);
		u_host.xfer(d, nb, rd);
	endtask
	task automatic st();
		cmd({8'h05, 16'h0000}, 16);
		chk({1'b0, rd}, {5'h00, e_prot, e_latch, e_busy});
	endtask
	task automatic idle();
		for (int i = 0; i < 1000 && busy !== 1'b0; i++)
			@(negedge clk);
		if (busy !== 1'b0)
		begin
			num_errors++;
			test_done();
		end
		e_busy = 1'b0;
	endtask
	task automatic set_prot(input logic [1:0] l);
		cmd({op(3'h6), 16'h0000}, 8);
		cmd({op(3'h1), 4'($urandom), l, 2'($urandom), 8'h00}, 16);
		{e_prot, e_latch, e_busy} = {l, 2'h1};
	endtask
	initial
	begin
		void'($urandom(32'h2000));
		{rstn, guard_n, density, e_prot, e_latch, e_busy} = 8'h40;
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		chk({so_oe, busy, latch, prot}, 9'h000);
		st();
		cmd({op(3'h6), 16'h0000}, 8);
		e_latch = 1'b1;
		st();
		cmd({op(3'h4), 16'h0000}, 8);
		e_latch = 1'b0;
		st();
		// a set that is not properly ended must not take
		cmd({op(3'h6), 16'h0000}, 9);
		st();
		cmd({op(3'h6), op(3'h2), 8'h00}, 24);
		st();
		cmd({op(3'h1), 8'h0C, 8'h00}, 16);
		st();
		// every protect code; a latch set while busy is dropped, a status read is answered
		for (int k = 0; k < 4; k++)
		begin
			u_host.half = 4 + $urandom % 4;
			set_prot(2'(k));
			cmd({op(3'h6), 16'h0000}, 8);
			st();
			idle();
			st();
		end
		// guard low beats the latch and blocks status writes
		cmd({op(3'h6), 16'h0000}, 8);
		guard_n = 1'b0;
		st();
		cmd({op(3'h6), 16'h0000}, 8);
		cmd({op(3'h1), 16'h0000}, 16);
		st();
		guard_n = 1'b1;
		// array writes at range edges and at random
		for (int t = 0; t < 12; t++)
		begin
			density = 2'($urandom % 3);
			set_prot(2'($urandom));
			idle();
			a = 9'($urandom % (128 << density));
			if (t % 3 == 0 && base(density, e_prot) < (10'h080 << density))
				a = 9'(base(density, e_prot) - 10'(t % 2));
			hit = 10'(a) >= base(density, e_prot);
			// address bits above the array size are junk and must not count
			sa = a | ({2'($urandom), 7'h00} & (density == 2'h0 ? 9'h180
				: density == 2'h1 ? 9'h100 : 9'h000));
			n = starts;
			cmd({op(3'h6), 16'h0000}, 8);
			cmd({4'h0, sa[8], 3'h2, sa[7:0], 8'($urandom)}, 24);
			chk(9'(starts - n), {8'h00, !hit});
			e_latch = hit;
			if (!hit)
			begin
				chk(waddr, sa);
				guard_n = 1'($urandom);
				idle();
				guard_n = 1'b1;
			end
			st();
		end
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		chk({so_oe, busy, latch}, 9'h000);
		chk({7'h00, prot}, {7'h00, e_prot});
		test_done();
	end
endmodule // ewps_core_tb
